// [sdbg_core.sv]
// design: single-wire background debug serial port, command engine and mode control
`timescale 1ns/100ps
// --------------------------------------------------------------
// --------------------------------------------------------------
module sdbg_core (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // debug serial pin
    input wire logic debug_serial_pin_i,
    output logic debug_serial_pin_o,
    output logic debug_serial_pin_oe_o,
    // mode strap and cpu status
    input wire logic special_single_chip_i,
    input wire logic cpu_free_cycle_i,
    input wire logic instr_boundary_i,
    input wire logic tag_hit_i,
    input wire logic enter_debug_instruction_i,
    input wire logic fw_exit_i,
    // cpu control
    output logic cpu_freeze_o,
    output logic background_debug_mode_o,
    output logic debug_map_o,
    output logic periph_suspend_o,
    output logic firmware_enable_bit_o,
    // firmware command hand-off
    output logic fw_cmd_valid_o,
    output logic [7:0] fw_cmd_o,
    // cpu memory bus
    output logic mem_req_valid_o,
    output sdbg_pkg::sdbg_mem_req_t mem_req_o,
    input wire logic mem_ack_i,
    input wire logic [15:0] mem_rdata_i
);
    // --------------------------------------------------------------
    // declarations
    // --------------------------------------------------------------
    typedef enum logic [2:0] {ST_OPC, ST_ADDR, ST_WDATA, ST_EXEC, ST_RWAIT, ST_TXD} sdbg_state_t;
    sdbg_state_t state_ff;
    logic pin_s1_ff, pin_s2_ff, pin_s3_ff, fall;
    logic [3:0] cnt_ff;
    logic bit_act_ff, rx_bit, tx_end;
    logic [9:0] idle_ff;
    logic timeout;
    logic [15:0] sh_ff, nxt_word;
    logic [4:0] bits_ff;
    logic [7:0] opc_ff;
    logic [15:0] addr_ff, data_ff;
    logic fw_en_ff, active_ff, halt_pend_ff, init_ff, ss_s1_ff, ss_s2_ff;
    logic [1:0] init_dly_ff;
    logic [2:0] reject_ff;
    logic op_read, op_word, op_bd, local_hit;
    // buffer
    sdbg_pkg::sdbg_mem_req_t fifo_q [2];
    logic wr_ptr_ff, rd_ptr_ff;
    logic [1:0] fill_ff;
    logic push, pop, fifo_full, fifo_empty;
    logic [7:0] wait_ff;
    logic steal_ff, mem_done_ff;
    logic [15:0] rdata_ff;

    // --------------------------------------------------------------
    // pin synchroniser and bit timing
    // --------------------------------------------------------------
    // two flops then an edge-detect flop
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1_ff <= 1'b1;
            pin_s2_ff <= 1'b1;
            pin_s3_ff <= 1'b1;
        end else begin
            pin_s1_ff <= debug_serial_pin_i;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
        end
    end
    assign fall = pin_s3_ff & ~pin_s2_ff;

    // per-bit counter, zero at the perceived bit start
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= 4'h0;
            bit_act_ff <= 1'b0;
        end else if (fall && !(bit_act_ff && state_ff == ST_TXD)) begin
            cnt_ff <= 4'h1;
            bit_act_ff <= 1'b1;
        end else if (bit_act_ff) begin
            cnt_ff <= cnt_ff + 4'h1;
            // a receive bit ends at its sample so a reply never inherits its count
            if (cnt_ff == 4'(sdbg_pkg::BIT_CYCLES - 1) || rx_bit) bit_act_ff <= 1'b0;
        end
    end
    assign rx_bit = bit_act_ff && cnt_ff == 4'(sdbg_pkg::SAMPLE_AT) && state_ff != ST_TXD;
    assign tx_end = bit_act_ff && cnt_ff == 4'(sdbg_pkg::BIT_CYCLES - 1) && state_ff == ST_TXD;

    // link idle time-out between host falling edges
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            idle_ff <= 10'h000;
        end else if (fall) begin
            idle_ff <= 10'h000;
        end else if (idle_ff != 10'(sdbg_pkg::TIMEOUT_CYCLES - 1)) begin
            idle_ff <= idle_ff + 10'h001;
        end
    end
    assign timeout = idle_ff == 10'(sdbg_pkg::TIMEOUT_CYCLES - 2);

    // pin drive: only while sending to the host
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            debug_serial_pin_o <= 1'b1;
            debug_serial_pin_oe_o <= 1'b0;
        end else if (state_ff != ST_TXD) begin
            debug_serial_pin_oe_o <= 1'b0;
            debug_serial_pin_o <= 1'b1;
        end else if (fall && !bit_act_ff && !sh_ff[15]) begin
            debug_serial_pin_oe_o <= 1'b1;
            debug_serial_pin_o <= 1'b0;
        end else if (bit_act_ff && !sh_ff[15]) begin
            if (cnt_ff == 4'(sdbg_pkg::ZERO_LOW)) debug_serial_pin_o <= 1'b1;
            if (cnt_ff == 4'(sdbg_pkg::ZERO_LOW + 1)) debug_serial_pin_oe_o <= 1'b0;
        end else if (bit_act_ff) begin
            if (cnt_ff == 4'(sdbg_pkg::SPEEDUP_AT - 1)) begin
                debug_serial_pin_oe_o <= 1'b1;
                debug_serial_pin_o <= 1'b1;
            end
            if (cnt_ff == 4'(sdbg_pkg::SPEEDUP_AT)) debug_serial_pin_oe_o <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // command engine
    // --------------------------------------------------------------
    assign nxt_word = {sh_ff[14:0], pin_s2_ff};
    assign op_read = opc_ff[sdbg_pkg::OPC_READ_POS];
    assign op_word = opc_ff[sdbg_pkg::OPC_WORD_POS];
    assign op_bd = opc_ff[sdbg_pkg::OPC_BDSP_POS];
    // debug-space commands reach the local registers before activation too
    assign local_hit = op_bd && addr_ff >= sdbg_pkg::DBG_REG_LO
        && addr_ff <= sdbg_pkg::DBG_REG_HI;
    assign push = state_ff == ST_EXEC && !local_hit && !fifo_full;

    // shift register, bit count and command state
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= ST_OPC;
            sh_ff <= 16'h0000;
            bits_ff <= 5'h00;
            opc_ff <= 8'h00;
            addr_ff <= 16'h0000;
            data_ff <= 16'h0000;
        end else if (timeout) begin
            state_ff <= ST_OPC;
            sh_ff <= 16'h0000;
            bits_ff <= 5'h00;
        end else begin
            unique case (state_ff)
                ST_OPC, ST_ADDR, ST_WDATA: begin
                    if (rx_bit) begin
                        sh_ff <= nxt_word;
                        bits_ff <= bits_ff + 5'h01;
                        if (state_ff == ST_OPC && bits_ff == 5'(sdbg_pkg::OPC_BITS - 1)) begin
                            bits_ff <= 5'h00;
                            opc_ff <= nxt_word[7:0];
                            if (nxt_word[7:6] == sdbg_pkg::OPC_HW_MEM) state_ff <= ST_ADDR;
                        end else if (state_ff != ST_OPC && bits_ff == 5'(sdbg_pkg::WORD_BITS - 1)) begin
                            bits_ff <= 5'h00;
                            if (state_ff == ST_ADDR) begin
                                addr_ff <= nxt_word;
                                state_ff <= op_read ? ST_EXEC : ST_WDATA;
                            end else begin
                                data_ff <= nxt_word;
                                state_ff <= ST_EXEC;
                            end
                        end
                    end
                end
                ST_EXEC: begin
                    if (local_hit && op_read) begin
                        sh_ff <= {8'h00, fw_en_ff, active_ff, 6'h00};
                        state_ff <= ST_TXD;
                    end else if (local_hit) begin
                        state_ff <= ST_OPC;
                    end else if (push) begin
                        state_ff <= op_read ? ST_RWAIT : ST_OPC;
                    end
                end
                ST_RWAIT: begin
                    if (mem_done_ff) begin
                        sh_ff <= rdata_ff;
                        state_ff <= ST_TXD;
                    end
                end
                ST_TXD: begin
                    if (tx_end) begin
                        sh_ff <= {sh_ff[14:0], 1'b0};
                        bits_ff <= bits_ff + 5'h01;
                        if (bits_ff == 5'(sdbg_pkg::WORD_BITS - 1)) begin
                            bits_ff <= 5'h00;
                            state_ff <= ST_OPC;
                        end
                    end
                end
            endcase
        end
    end

    // firmware opcodes pass to the debug rom only while active
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fw_cmd_valid_o <= 1'b0;
            fw_cmd_o <= 8'h00;
        end else begin
            fw_cmd_valid_o <= state_ff == ST_OPC && rx_bit && !timeout && active_ff
                && bits_ff == 5'(sdbg_pkg::OPC_BITS - 1) && nxt_word[7:6] != sdbg_pkg::OPC_HW_MEM
                && nxt_word[7:0] != sdbg_pkg::OPC_BACKGROUND;
            fw_cmd_o <= nxt_word[7:0];
        end
    end

    // --------------------------------------------------------------
    // mode control
    // --------------------------------------------------------------
    // strap caught after reset release
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ss_s1_ff <= 1'b0;
            ss_s2_ff <= 1'b0;
        end else begin
            ss_s1_ff <= special_single_chip_i;
            ss_s2_ff <= ss_s1_ff;
        end
    end

    // enable, halt request, active mode and reject delay
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            init_ff <= 1'b0;
            init_dly_ff <= 2'h0;
            fw_en_ff <= sdbg_pkg::ST_RESET[sdbg_pkg::ST_FW_EN_POS];
            active_ff <= sdbg_pkg::ST_RESET[sdbg_pkg::ST_ACTIVE_POS];
            halt_pend_ff <= 1'b0;
            reject_ff <= 3'h0;
        end else begin
            // hold init low until the strap has crossed both flops
            init_dly_ff <= {init_dly_ff[0], 1'b1};
            init_ff <= init_dly_ff[1];
            if (!init_ff && ss_s2_ff) begin
                fw_en_ff <= 1'b1;
                active_ff <= 1'b1;
            end
            if (state_ff == ST_EXEC && local_hit && !op_read && (op_word
                    ? addr_ff == sdbg_pkg::DBG_REG_LO : addr_ff == sdbg_pkg::DBG_STATUS_ADDR))
                fw_en_ff <= data_ff[sdbg_pkg::ST_FW_EN_POS];
            if (state_ff == ST_OPC && rx_bit && !timeout && bits_ff == 5'(sdbg_pkg::OPC_BITS - 1)
                    && nxt_word[7:0] == sdbg_pkg::OPC_BACKGROUND) begin
                if (fw_en_ff) halt_pend_ff <= 1'b1;
                else reject_ff <= 3'(sdbg_pkg::REJECT_CYCLES);
            end
            if (fw_en_ff && !active_ff && (tag_hit_i || enter_debug_instruction_i
                    || (halt_pend_ff && instr_boundary_i))) begin
                active_ff <= 1'b1;
                halt_pend_ff <= 1'b0;
            end else if (active_ff && fw_exit_i) begin
                active_ff <= 1'b0;
            end
            if (!fw_en_ff && (tag_hit_i || enter_debug_instruction_i))
                reject_ff <= 3'(sdbg_pkg::REJECT_CYCLES);
            else if (reject_ff != 3'h0)
                reject_ff <= reject_ff - 3'h1;
        end
    end

    // mode outputs straight from flops
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            background_debug_mode_o <= 1'b0;
            debug_map_o <= 1'b0;
            periph_suspend_o <= 1'b0;
            firmware_enable_bit_o <= 1'b0;
            cpu_freeze_o <= 1'b0;
        end else begin
            background_debug_mode_o <= active_ff;
            debug_map_o <= active_ff;
            periph_suspend_o <= active_ff;
            firmware_enable_bit_o <= fw_en_ff;
            cpu_freeze_o <= steal_ff || reject_ff != 3'h0;
        end
    end

    // --------------------------------------------------------------
    // two-entry request buffer and bus access
    // --------------------------------------------------------------
    assign fifo_full = fill_ff == 2'h2;
    assign fifo_empty = fill_ff == 2'h0;
    assign pop = !fifo_empty && !mem_req_valid_o && (cpu_free_cycle_i || steal_ff);

    // buffer storage and pointers
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            fill_ff <= 2'h0;
            fifo_q[0] <= '0;
            fifo_q[1] <= '0;
        end else begin
            if (push) begin
                fifo_q[wr_ptr_ff] <= '{addr: addr_ff, wdata: data_ff, write: !op_read,
                    word: op_word, bd_space: op_bd};
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) rd_ptr_ff <= ~rd_ptr_ff;
            fill_ff <= fill_ff + {1'b0, push} - {1'b0, pop};
        end
    end

    // free-cycle wait, steal and bus handshake
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_ff <= 8'h00;
            steal_ff <= 1'b0;
            mem_req_valid_o <= 1'b0;
            mem_req_o <= '0;
            mem_done_ff <= 1'b0;
            rdata_ff <= 16'h0000;
        end else begin
            mem_done_ff <= 1'b0;
            if (pop) begin
                wait_ff <= 8'h00;
                mem_req_valid_o <= 1'b1;
                mem_req_o <= fifo_q[rd_ptr_ff];
            end else if (!fifo_empty && !mem_req_valid_o && wait_ff != 8'(sdbg_pkg::STEAL_WAIT)) begin
                wait_ff <= wait_ff + 8'h01;
                if (wait_ff == 8'(sdbg_pkg::STEAL_WAIT - 1)) steal_ff <= 1'b1;
            end
            if (mem_req_valid_o && mem_ack_i) begin
                mem_req_valid_o <= 1'b0;
                steal_ff <= 1'b0;
                mem_done_ff <= !mem_req_o.write;
                rdata_ff <= mem_rdata_i;
            end
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    sequence s_zero_start;
        state_ff == ST_TXD && fall && !bit_act_ff && !sh_ff[15];
    endsequence
    sequence s_one_mid;
        state_ff == ST_TXD && bit_act_ff && sh_ff[15] && cnt_ff == 4'h6;
    endsequence

    a_timeout_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        timeout |=> state_ff == ST_OPC && bits_ff == 5'h00) else $error("time-out left command");
    a_zero_low_time: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_zero_start ##1 !timeout |-> (debug_serial_pin_oe_o && !debug_serial_pin_o) [*8]
        ##5 debug_serial_pin_oe_o && !debug_serial_pin_o ##1 debug_serial_pin_oe_o && debug_serial_pin_o)
        else $error("zero bit drive wrong");
    a_one_speedup: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_one_mid ##1 state_ff == ST_TXD |-> debug_serial_pin_oe_o && debug_serial_pin_o
        ##1 !debug_serial_pin_oe_o) else $error("one bit speed-up wrong");
    a_rx_undriven: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(state_ff) != ST_TXD |-> !debug_serial_pin_oe_o) else $error("pin driven while host sends");
    a_sample_point: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        fall && state_ff != ST_TXD && !bit_act_ff ##1 !fall [*8] ##1 !fall |=> cnt_ff == 4'(sdbg_pkg::SAMPLE_AT))
        else $error("sample point misplaced");
    a_steal_freeze: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(steal_ff) |-> $past(wait_ff) == 8'(sdbg_pkg::STEAL_WAIT - 1) ##1 cpu_freeze_o)
        else $error("steal not after wait");
    a_reject_no_mode: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !fw_en_ff && !active_ff && init_ff && enter_debug_instruction_i |=> !active_ff ##1 cpu_freeze_o)
        else $error("disabled activation misbehaved");
    a_fw_cmd_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        fw_cmd_valid_o |-> $past(active_ff)) else $error("firmware command while inactive");
    a_halt_boundary: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        halt_pend_ff && !active_ff && !tag_hit_i && !enter_debug_instruction_i && !instr_boundary_i
        |=> !active_ff) else $error("halt before boundary");
    a_special_entry: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !init_ff && ss_s2_ff |=> active_ff && fw_en_ff ##1 background_debug_mode_o)
        else $error("special mode not active");
endmodule : sdbg_core

// [sdbg_pkg.sv]
// package: constants and types for the single-wire background debug block
package sdbg_pkg;
    // bit framing, link time-out, steal wait and reject freeze in debug clock cycles
    localparam int unsigned BIT_CYCLES = 16;
    localparam int unsigned SAMPLE_AT = 10;
    localparam int unsigned SPEEDUP_AT = 7;
    localparam int unsigned ZERO_LOW = 13;
    localparam int unsigned TIMEOUT_CYCLES = 512;
    localparam int unsigned STEAL_WAIT = 128;
    localparam int unsigned REJECT_CYCLES = 4;
    // field sizes
    localparam int unsigned OPC_BITS = 8;
    localparam int unsigned WORD_BITS = 16;
    // opcodes and opcode fields
    localparam logic [7:0] OPC_BACKGROUND = 8'h90;
    localparam logic [1:0] OPC_HW_MEM = 2'h3;
    localparam int unsigned OPC_READ_POS = 5;
    localparam int unsigned OPC_WORD_POS = 3;
    localparam int unsigned OPC_BDSP_POS = 2;
    // debug space addresses
    localparam logic [15:0] DBG_REG_LO = 16'hff00;
    localparam logic [15:0] DBG_REG_HI = 16'hff06;
    localparam logic [15:0] DBG_STATUS_ADDR = 16'hff01;
    // status register fields and reset value
    localparam int unsigned ST_FW_EN_POS = 7;
    localparam int unsigned ST_ACTIVE_POS = 6;
    localparam logic [7:0] ST_RESET = 8'h00;

    // one memory access handed to the cpu bus
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic write;
        logic word;
        logic bd_space;
    } sdbg_mem_req_t;
endpackage : sdbg_pkg

// [sdbg_host.sv]
// host development system model that drives the debug serial pin
`timescale 1ns/100ps
module sdbg_host (
    // clock
    input wire logic ref_clk_i,
    // resolved pin level and low drive
    input wire logic pin_i,
    output logic pull_low_o
);
    initial pull_low_o = 1'b0;
    // send n bits, twenty cycles each, low held long for a zero
    task automatic send(input int n, input logic [15:0] v);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge ref_clk_i) pull_low_o <= 1'b1;
            repeat (v[i] ? 4 : 15) @(posedge ref_clk_i);
            pull_low_o <= 1'b0;
            repeat (v[i] ? 15 : 4) @(posedge ref_clk_i);
        end
    endtask : send
    // receive one word, starting every bit with a short low pulse
    task automatic recv(output logic [15:0] v);
        for (int i = 15; i >= 0; i--) begin
            @(posedge ref_clk_i) pull_low_o <= 1'b1;
            repeat (2) @(posedge ref_clk_i);
            pull_low_o <= 1'b0;
            repeat (8) @(posedge ref_clk_i);
            @(negedge ref_clk_i) v[i] = pin_i;
            repeat (9) @(posedge ref_clk_i);
        end
    endtask : recv
endmodule : sdbg_host

// [single_wire_background_debug_bench.sv]
// self-checking bench for the background debug core
`timescale 1ns/100ps
module single_wire_background_debug_bench;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, free_cyc = 1'b1, bndry = 1'b0, tag = 1'b0, bgi = 1'b0, fw_exit = 1'b0;
    logic ack = 1'b0, host_low, pin_o, pin_oe, freeze, background_debug_mode, dmap, susp, fw_en;
    logic req_v, strap = 1'b0, fw_v;
    logic [7:0] fw_c, fw_seen = 8'h00;
    logic [15:0] word;
    sdbg_pkg::sdbg_mem_req_t req, seen;
    int error_cnt = 0, n_checks = 0, n, n_fw = 0;
    // pull-up unless a party drives the pin
    wire logic pin = pin_oe ? pin_o : ~host_low;
    always #50 ref_clk_i = ~ref_clk_i;
    // memory responder, acks a cycle after each request
    always @(posedge ref_clk_i) begin
        ack <= req_v && !ack;
        bndry <= ~bndry;
        if (req_v) seen <= req;
        if (fw_v) begin
            fw_seen <= fw_c;
            n_fw <= n_fw + 1;
        end
    end
    sdbg_host host (.ref_clk_i(ref_clk_i), .pin_i(pin), .pull_low_o(host_low));
    sdbg_core dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .debug_serial_pin_i(pin), .debug_serial_pin_o(pin_o),
        .debug_serial_pin_oe_o(pin_oe), .special_single_chip_i(strap), .cpu_free_cycle_i(free_cyc),
        .instr_boundary_i(bndry), .tag_hit_i(tag), .enter_debug_instruction_i(bgi), .fw_exit_i(fw_exit),
        .cpu_freeze_o(freeze), .background_debug_mode_o(background_debug_mode), .debug_map_o(dmap), .periph_suspend_o(susp),
        .firmware_enable_bit_o(fw_en), .fw_cmd_valid_o(fw_v), .fw_cmd_o(fw_c), .mem_req_valid_o(req_v),
        .mem_req_o(req), .mem_ack_i(ack), .mem_rdata_i(16'ha5c3));
    // compare one value
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // counts and verdict
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    // activation attempts while disabled only freeze briefly
    task automatic t_reject;
        fork
            host.send(8, 16'h0090);
            begin
                n = 0;
                repeat (200) @(posedge ref_clk_i) n += freeze;
            end
        join
        chk("reject freeze", 16'(sdbg_pkg::REJECT_CYCLES), n[15:0]);
        @(posedge ref_clk_i) bgi <= 1'b1;
        @(posedge ref_clk_i) bgi <= 1'b0;
        n = 0;
        repeat (10) @(posedge ref_clk_i) n += freeze;
        chk("reject freeze instr", 16'(sdbg_pkg::REJECT_CYCLES), n[15:0]);
        chk("no activation", 16'h0, {15'h0, background_debug_mode});
    endtask : t_reject
    // enable firmware by debug-space byte write
    task automatic t_enable;
        host.send(8, 16'h00c4);
        host.send(16, 16'hff01);
        host.send(16, 16'h0080);
        repeat (30) @(posedge ref_clk_i);
        chk("fw enable", 16'h1, {15'h0, fw_en});
    endtask : t_enable
    // halt command, tag and enter-debug instruction each activate
    task automatic t_activate;
        for (int k = 0; k < 3; k++) begin
            if (k == 0) host.send(8, 16'h0090);
            @(posedge ref_clk_i) {tag, bgi} <= (k == 1) ? 2'h2 : (k == 2) ? 2'h1 : 2'h0;
            @(posedge ref_clk_i) {tag, bgi} <= 2'h0;
            for (n = 0; n < 40 && background_debug_mode !== 1'b1; n++) @(posedge ref_clk_i);
            if (n == 40) begin
                error_cnt++;
                wrap_up();
            end
            @(negedge ref_clk_i) chk("active map suspend", 16'h7, {13'h0, background_debug_mode, dmap, susp});
            if (k == 0) begin
                host.send(8, 16'h0063);
                chk("fw opcode", 16'h0163, {7'h0, (n_fw == 1), fw_seen});
            end
            @(posedge ref_clk_i) fw_exit <= 1'b1;
            @(posedge ref_clk_i) fw_exit <= 1'b0;
            repeat (4) @(posedge ref_clk_i);
            chk("left active", 16'h0, {13'h0, background_debug_mode, dmap, susp});
        end
    endtask : t_activate
    // partial command dropped by time-out, then read with a stolen cycle
    task automatic t_read;
        free_cyc <= 1'b0;
        host.send(3, 16'h0007);
        repeat (600) @(posedge ref_clk_i);
        host.send(8, 16'h00e0);
        host.send(16, 16'h1234);
        for (n = 0; n < 300 && freeze !== 1'b1; n++) @(posedge ref_clk_i);
        chk("steal delay", 16'h1, {15'h0, n > 100 && n < 140});
        repeat (200 - n) @(posedge ref_clk_i);
        host.recv(word);
        chk("read word", 16'ha5c3, word);
        chk("bus addr", 16'h1234, seen.addr);
        chk("bus read", 16'h0, {15'h0, seen.write});
        free_cyc <= 1'b1;
    endtask : t_read
    // mid-run reset with the special strap set comes out enabled and active
    task automatic t_special;
        @(posedge ref_clk_i) begin
            rst_i <= 1'b1;
            strap <= 1'b1;
        end
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(negedge ref_clk_i) chk("reset mode again", 16'h0, {13'h0, background_debug_mode, fw_en, freeze});
        repeat (6) @(posedge ref_clk_i);
        chk("special entry", 16'h3, {14'h0, background_debug_mode, fw_en});
    endtask : t_special
    // main sequence
    initial begin
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(negedge ref_clk_i);
        chk("reset pins", 16'h1, {14'h0, pin_oe, pin_o});
        chk("reset mode", 16'h0, {13'h0, background_debug_mode, fw_en, freeze});
        repeat (10) @(posedge ref_clk_i);
        t_reject();
        $display("test reject done");
        t_enable();
        $display("test enable done");
        t_activate();
        $display("test activate done");
        t_read();
        $display("test read done");
        t_special();
        $display("test special done");
        wrap_up();
    end
endmodule : single_wire_background_debug_bench
